// [verilog/ssr_encoder_reader.sv]
// Module: serial absolute encoder reader with APB registers and status indicators
//
// Our own choices: the placing of the registers and the APB register port.
`default_nettype none
module ssr_encoder_reader
  import ssr_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_FAST_CYC
) (
  // System
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder link
  input wire logic linkClk,
  output logic encoderClockOut,
  input wire logic encoderDataIn,
  // Latch input
  input wire logic latchTriggerInput,
  // Indicators
  output logic sysStatusBlue,
  output logic sysStatusRed,
  output logic ledCommOk,
  output logic ledFwd,
  output logic ledRev,
  output logic ledCmp1,
  output logic ledCmp2,
  output logic ledLatchIn
);
  logic [31:0] ctrl_r, cmp_r [2], value_r, pos_r, prevPos_r, latch_r;
  logic [15:0] div_r;
  logic configured_r, cfgTgl_r, fwd_r, rev_r, commOk_r, frameSeen_r;
  logic parErr_r, txErr_r, wireBreak_r, latchValid_r;
  logic [1:0] cmpRes_r;
  logic wrEn, setup, mapped, latchClr, paramErr, engineEn;
  logic [4:0] nBits, specBits;
  logic [31:0] rdMux;

  // APB access decode
  assign wrEn = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign pready = psel & penable;
  assign mapped = paddr inside {OFS_CTRL, OFS_STATUS, OFS_POS, OFS_VALUE, OFS_LATCH,
                                OFS_CMP1, OFS_CMP2, OFS_DIV};
  assign pslverr = psel & penable & ~mapped;
  assign latchClr = wrEn & (paddr == OFS_CTRL) & pwdata[CT_LATCH_CLR];
  assign nBits = ctrl_r[CT_NBITS +: 5];
  assign specBits = ctrl_r[CT_SPEC +: 5];
  // Position must keep at least one bit after special and parity bits
  assign paramErr = configured_r & ((nBits < WORD_MIN) |
    ({1'b0, specBits} + {5'h00, ctrl_r[CT_PAR_EN]} >= {1'b0, nBits}));
  assign engineEn = configured_r & ~paramErr & ctrl_r[CT_ADMIT] & ctrl_r[CT_RUN];

  // Writable registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
      div_r <= DIV_RST;
      cmp_r[0] <= '0;
      cmp_r[1] <= '0;
      configured_r <= 1'b0;
      cfgTgl_r <= 1'b0;
    end else if (wrEn) begin
      case (paddr)
        OFS_CTRL: begin
          ctrl_r <= pwdata & ~(32'h1 << CT_LATCH_CLR);
          configured_r <= 1'b1;
          cfgTgl_r <= ~cfgTgl_r;
        end
        OFS_DIV: begin
          div_r <= (pwdata[15:0] < DIV_MIN) ? DIV_MIN : pwdata[15:0];
          cfgTgl_r <= ~cfgTgl_r;
        end
        OFS_CMP1: cmp_r[0] <= pwdata;
        OFS_CMP2: cmp_r[1] <= pwdata;
        default: ;
      endcase
    end
  end

  // Read data is prepared in the setup phase so the access phase needs no wait
  always_comb begin
    rdMux = '0;
    case (paddr)
      OFS_CTRL: rdMux = ctrl_r;
      OFS_STATUS: begin
        rdMux[ST_COMM_OK] = commOk_r;
        rdMux[ST_FWD] = fwd_r;
        rdMux[ST_REV] = rev_r;
        rdMux[ST_CMP1] = cmpRes_r[0];
        rdMux[ST_CMP2] = cmpRes_r[1];
        rdMux[ST_LATCH_IN] = ledLatchIn;
        rdMux[ST_LATCH_VALID] = latchValid_r;
        rdMux[ST_PAR_ERR] = parErr_r;
        rdMux[ST_TX_ERR] = txErr_r;
        rdMux[ST_WIRE_BREAK] = wireBreak_r;
        rdMux[ST_PARAM_ERR] = paramErr;
        rdMux[ST_CONFIGURED] = configured_r;
      end
      OFS_POS: rdMux = pos_r;
      OFS_VALUE: rdMux = value_r;
      OFS_LATCH: rdMux = latch_r;
      OFS_CMP1: rdMux = cmp_r[0];
      OFS_CMP2: rdMux = cmp_r[1];
      OFS_DIV: rdMux = {16'h0000, div_r};
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= rdMux;
    end
  end

  // Link domain: reset, data pin and configuration crossings
  logic lrstS1, lrst, dataS1, dataS2, cfgS1, cfgS2, cfgS3;
  logic [15:0] lDiv, divCnt;
  logic [4:0] lNBits;
  logic lRepeat, lEnable, tick;

  always_ff @(posedge linkClk) begin
    lrstS1 <= sys_rst;
    lrst <= lrstS1;
    dataS1 <= encoderDataIn;
    dataS2 <= dataS1;
  end

  // Settings are quasi-static: software writes them while the link is stopped
  always_ff @(posedge linkClk) begin
    if (lrst) begin
      cfgS1 <= 1'b0;
      cfgS2 <= 1'b0;
      cfgS3 <= 1'b0;
      lDiv <= DIV_RST;
      lNBits <= CTRL_RST[CT_NBITS +: 5];
      lRepeat <= 1'b0;
      lEnable <= 1'b0;
    end else begin
      cfgS1 <= cfgTgl_r;
      cfgS2 <= cfgS1;
      cfgS3 <= cfgS2;
      if (cfgS2 ^ cfgS3) begin
        lDiv <= div_r;
        lNBits <= nBits;
        lRepeat <= ctrl_r[CT_REPEAT];
        lEnable <= engineEn;
      end
    end
  end

  // Half-period divider of the encoder clock
  assign tick = (divCnt == 16'h0000);
  always_ff @(posedge linkClk) begin
    if (lrst) begin
      divCnt <= DIV_RST;
    end else begin
      divCnt <= tick ? lDiv - 16'h0001 : divCnt - 16'h0001;
    end
  end

  // Burst sequencer
  ssr_lstate_t lState;
  logic [5:0] pulseCnt;
  logic [6:0] gapCnt;
  logic [31:0] shift_r, first_r, rxWord_r;
  logic copyIdx, pend_r, chkLow, wbAcc, txAcc, rxTxErr, rxWb, doneTgl;

  always_ff @(posedge linkClk) begin
    if (lrst) begin
      lState <= LS_PAUSE;
      encoderClockOut <= 1'b1;
      pulseCnt <= '0;
      gapCnt <= FRAME_GAP_TICKS;
      shift_r <= '0;
      first_r <= '0;
      rxWord_r <= '0;
      copyIdx <= 1'b0;
      pend_r <= 1'b0;
      chkLow <= 1'b0;
      wbAcc <= 1'b0;
      txAcc <= 1'b0;
      rxTxErr <= 1'b0;
      rxWb <= 1'b0;
      doneTgl <= 1'b0;
    end else if (tick) begin
      case (lState)
        LS_PAUSE: begin
          encoderClockOut <= 1'b1;
          chkLow <= 1'b0;
          if (chkLow && dataS2) begin
            wbAcc <= 1'b1;
          end
          if (gapCnt != 7'h00) begin
            gapCnt <= gapCnt - 7'h01;
          end else begin
            if (pend_r && !copyIdx) begin
              rxWord_r <= shift_r;
              rxTxErr <= txAcc;
              rxWb <= wbAcc | (chkLow & dataS2);
              doneTgl <= ~doneTgl;
              pend_r <= 1'b0;
            end
            if (lEnable || copyIdx) begin
              if (!copyIdx) begin
                wbAcc <= ~dataS2;
                txAcc <= 1'b0;
              end
              encoderClockOut <= 1'b0;
              pulseCnt <= 6'h01;
              shift_r <= '0;
              lState <= LS_LOW;
            end
          end
        end
        LS_LOW: begin
          encoderClockOut <= 1'b1;
          if (pulseCnt == {1'b0, lNBits} + 6'h01) begin
            lState <= LS_PAUSE;
            chkLow <= 1'b1;
            if (lRepeat && !copyIdx) begin
              first_r <= shift_r;
              copyIdx <= 1'b1;
              gapCnt <= REPEAT_GAP_TICKS;
            end else begin
              if (lRepeat && shift_r != first_r) begin
                txAcc <= 1'b1;
              end
              copyIdx <= 1'b0;
              pend_r <= 1'b1;
              gapCnt <= FRAME_GAP_TICKS;
            end
          end else begin
            lState <= LS_HIGH;
          end
        end
        LS_HIGH: begin
          // Falling edge of the next pulse: the bit shifted out by the last rise
          encoderClockOut <= 1'b0;
          pulseCnt <= pulseCnt + 6'h01;
          shift_r <= {shift_r[30:0], dataS2};
          lState <= LS_LOW;
        end
        default: lState <= LS_PAUSE;
      endcase
    end
  end

  // Frame event into the register domain
  logic doneS1, doneS2, doneS3, frameEv;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      doneS1 <= 1'b0;
      doneS2 <= 1'b0;
      doneS3 <= 1'b0;
    end else begin
      doneS1 <= doneTgl;
      doneS2 <= doneS1;
      doneS3 <= doneS2;
    end
  end
  assign frameEv = doneS2 ^ doneS3;

  // Word decode
  function automatic logic [31:0] grayToBin(input logic [31:0] g);
    logic [31:0] b;
    b[31] = g[31];
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  logic [31:0] body, appMask, posRaw, posBin, valueOut;
  logic parOk, moveFwd, moveRev;
  always_comb begin
    parOk = (^rxWord_r) == ctrl_r[CT_PAR_ODD];
    body = ctrl_r[CT_PAR_EN] ? rxWord_r >> 1 : rxWord_r;
    appMask = (32'h1 << specBits) - 32'h1;
    posRaw = body >> specBits;
    posBin = ctrl_r[CT_GRAY] ? grayToBin(posRaw) : posRaw;
    valueOut = ctrl_r[CT_NORM] ? posBin : (posBin << specBits) | (body & appMask);
    moveFwd = ctrl_r[CT_DIR_INV] ? (posBin < pos_r) : (posBin > pos_r);
    moveRev = ctrl_r[CT_DIR_INV] ? (posBin > pos_r) : (posBin < pos_r);
  end

  // Position, direction and error flags; a new error wins over a clear
  logic errClr;
  assign errClr = wrEn & (paddr == OFS_STATUS);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pos_r <= '0;
      prevPos_r <= '0;
      value_r <= '0;
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      commOk_r <= 1'b0;
      frameSeen_r <= 1'b0;
      parErr_r <= 1'b0;
      txErr_r <= 1'b0;
      wireBreak_r <= 1'b0;
    end else begin
      if (frameEv) begin
        prevPos_r <= pos_r;
        pos_r <= posBin;
        value_r <= valueOut;
        fwd_r <= frameSeen_r & moveFwd;
        rev_r <= frameSeen_r & moveRev;
        frameSeen_r <= 1'b1;
        commOk_r <= ~rxTxErr & ~rxWb & (parOk | ~ctrl_r[CT_PAR_EN]);
      end
      parErr_r <= (frameEv & ctrl_r[CT_PAR_EN] & ~parOk) |
                  (parErr_r & ~(errClr & pwdata[ST_PAR_ERR]));
      txErr_r <= (frameEv & rxTxErr) | (txErr_r & ~(errClr & pwdata[ST_TX_ERR]));
      wireBreak_r <= (frameEv & rxWb) |
                     (wireBreak_r & ~(errClr & pwdata[ST_WIRE_BREAK]));
    end
  end

  // Comparators keep their result while moving against their direction
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmpRes_r <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        case (ssr_cmp_t'(ctrl_r[CT_CMP1 + 2 * k +: 2]))
          CMP_FWD: if (fwd_r) cmpRes_r[k] <= pos_r >= cmp_r[k];
          CMP_REV: if (rev_r) cmpRes_r[k] <= pos_r <= cmp_r[k];
          default: cmpRes_r[k] <= 1'b0;
        endcase
      end
    end
  end

  // Latch input: synchronised, edge detected, frozen until cleared
  logic latS1, latS2, latS3, latchEv;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      latS1 <= 1'b0;
      latS2 <= 1'b0;
      latS3 <= 1'b0;
    end else begin
      latS1 <= latchTriggerInput;
      latS2 <= latS1;
      latS3 <= latS2;
    end
  end
  assign latchEv = ctrl_r[CT_LATCH_EN] &
    (ctrl_r[CT_LATCH_FALL] ? (~latS2 & latS3) : (latS2 & ~latS3));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      latch_r <= '0;
      latchValid_r <= 1'b0;
    end else if (latchEv && (!latchValid_r || latchClr)) begin
      latch_r <= pos_r;
      latchValid_r <= 1'b1;
    end else if (latchClr) begin
      latchValid_r <= 1'b0;
    end
  end

  // Blink timebase; long period is a parameter so simulation can shorten it
  logic [31:0] blinkCnt;
  logic [1:0] slowCnt;
  logic fastPh, slowPh;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      blinkCnt <= '0;
      slowCnt <= '0;
      fastPh <= 1'b0;
      slowPh <= 1'b0;
    end else if (blinkCnt == 32'(BLINK_CYC - 1)) begin
      blinkCnt <= '0;
      fastPh <= ~fastPh;
      slowCnt <= slowCnt + 2'h1;
      if (slowCnt == SLOW_PER_FAST) begin
        slowPh <= ~slowPh;
      end
    end else begin
      blinkCnt <= blinkCnt + 32'h1;
    end
  end

  // Indicators
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sysStatusBlue <= 1'b0;
      sysStatusRed <= 1'b0;
      ledCommOk <= 1'b0;
      ledFwd <= 1'b0;
      ledRev <= 1'b0;
      ledCmp1 <= 1'b0;
      ledCmp2 <= 1'b0;
      ledLatchIn <= 1'b0;
    end else begin
      if (paramErr) begin
        sysStatusBlue <= 1'b0;
        sysStatusRed <= slowPh;
      end else if (wireBreak_r) begin
        sysStatusBlue <= 1'b0;
        sysStatusRed <= 1'b1;
      end else if (!configured_r || !ctrl_r[CT_ADMIT]) begin
        sysStatusBlue <= fastPh;
        sysStatusRed <= 1'b0;
      end else begin
        sysStatusBlue <= ctrl_r[CT_RUN] | slowPh;
        sysStatusRed <= 1'b0;
      end
      ledCommOk <= commOk_r & engineEn;
      ledFwd <= fwd_r;
      ledRev <= rev_r;
      ledCmp1 <= cmpRes_r[0];
      ledCmp2 <= cmpRes_r[1];
      ledLatchIn <= latS2;
    end
  end

  // Checks on the link side
  sequence burstEnd;
    tick && lState == LS_LOW && pulseCnt == {1'b0, lNBits} + 6'h01;
  endsequence

  a_burst_pulse_count: assert property (@(posedge linkClk) disable iff (lrst)
    burstEnd |=> lState == LS_PAUSE && encoderClockOut)
    else $error("burst did not end after n+1 pulses");
  a_clock_rests_high: assert property (@(posedge linkClk) disable iff (lrst)
    lState == LS_PAUSE && !(tick && gapCnt == 7'h00) |=> encoderClockOut)
    else $error("encoder clock low while pausing");
  a_repeat_gap_min: assert property (@(posedge linkClk) disable iff (lrst)
    burstEnd |=> lState == LS_PAUSE [*2])
    else $error("idle gap shorter than required");
  a_wire_break_start: assert property (@(posedge linkClk) disable iff (lrst)
    tick && lState == LS_PAUSE && gapCnt == 7'h00 && lEnable && !copyIdx && !dataS2
    |=> wbAcc)
    else $error("low idle data not flagged");

  // Checks on the register side
  a_tx_err_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    frameEv && rxTxErr |=> txErr_r && !commOk_r)
    else $error("copy mismatch not reported");
  a_latch_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
    latchValid_r && !latchClr |=> $stable(latch_r) && latchValid_r)
    else $error("latched value changed");
  a_dir_exclusive: assert property (@(posedge mclk) disable iff (sys_rst)
    frameEv && frameSeen_r ##1 1 |-> !(fwd_r && rev_r) && (fwd_r == $past(moveFwd)))
    else $error("direction flags wrong");
  a_idle_blink_blue: assert property (@(posedge mclk) disable iff (sys_rst)
    !configured_r && !wireBreak_r |=> !sysStatusRed)
    else $error("red shown while idle");
  a_parity_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    frameEv && ctrl_r[CT_PAR_EN] && !parOk |=> parErr_r)
    else $error("parity failure not flagged");
endmodule
`default_nettype wire

// [verilog/ssr_pkg.sv]
// Package: register map, field layout, reset values and timing of the encoder reader
`default_nettype none
// How it works
// - Drive encoder clock, receive encoder data
// - n+1 clock pulses, then idle period
// - Repeat bursts with extra idle period between
// - Differing repeated copies flag transmission error
// - Word length configurable from 8 to 31
// - Selectable serial clock, at most 2 MHz
// - Optional Gray to binary conversion
// - Optional parity check with failure flag
// - Appended special bits kept for host
// - Normalization keeps only position bits
// - Latch input edge freezes position
// - Configurable counting direction reversal
// - Two reference values, two compare results
// - Status indicator colours and blink patterns
// - Idle while not admitted to running
// - Indicators for comm, direction, compares, latch
package ssr_pkg;
  // Clock rates and serial limits
  localparam int MCLK_KHZ = 10000;
  localparam int LINK_CLK_KHZ = 166667;
  localparam int MAX_SSI_HZ = 2000000;
  localparam logic [15:0] DIV_MIN =
    16'((LINK_CLK_KHZ * 1000 + 2 * MAX_SSI_HZ - 1) / (2 * MAX_SSI_HZ));
  localparam logic [15:0] DIV_RST = 16'h0054;
  localparam int BLINK_FAST_MS = 125;
  localparam int BLINK_FAST_CYC = BLINK_FAST_MS * MCLK_KHZ;
  localparam logic [1:0] SLOW_PER_FAST = 2'h3;
  localparam logic [6:0] FRAME_GAP_TICKS = 7'h20;
  localparam logic [6:0] REPEAT_GAP_TICKS = 7'h02;
  // Word length limits
  localparam logic [4:0] WORD_MIN = 5'h08;
  localparam logic [4:0] WORD_MAX = 5'h1f;
  // Register offsets
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_POS = 8'h08;
  localparam logic [7:0] OFS_VALUE = 8'h0c;
  localparam logic [7:0] OFS_LATCH = 8'h10;
  localparam logic [7:0] OFS_CMP1 = 8'h14;
  localparam logic [7:0] OFS_CMP2 = 8'h18;
  localparam logic [7:0] OFS_DIV = 8'h1c;
  // Control fields
  localparam int CT_NBITS = 0;
  localparam int CT_SPEC = 5;
  localparam int CT_GRAY = 10;
  localparam int CT_PAR_EN = 11;
  localparam int CT_PAR_ODD = 12;
  localparam int CT_REPEAT = 13;
  localparam int CT_NORM = 14;
  localparam int CT_DIR_INV = 15;
  localparam int CT_LATCH_EN = 16;
  localparam int CT_LATCH_FALL = 17;
  localparam int CT_LATCH_CLR = 18;
  localparam int CT_ADMIT = 19;
  localparam int CT_RUN = 20;
  localparam int CT_CMP1 = 21;
  localparam int CT_CMP2 = 23;
  localparam logic [31:0] CTRL_RST = 32'h0000_0019;
  // Status fields
  localparam int ST_COMM_OK = 0;
  localparam int ST_FWD = 1;
  localparam int ST_REV = 2;
  localparam int ST_CMP1 = 3;
  localparam int ST_CMP2 = 4;
  localparam int ST_LATCH_IN = 5;
  localparam int ST_LATCH_VALID = 6;
  localparam int ST_PAR_ERR = 7;
  localparam int ST_TX_ERR = 8;
  localparam int ST_WIRE_BREAK = 9;
  localparam int ST_PARAM_ERR = 10;
  localparam int ST_CONFIGURED = 11;
  // Comparator modes and link states
  typedef enum logic [1:0] {CMP_OFF = 2'h0, CMP_FWD = 2'h1, CMP_REV = 2'h2} ssr_cmp_t;
  typedef enum logic [2:0] {LS_PAUSE = 3'b001, LS_LOW = 3'b010, LS_HIGH = 3'b100} ssr_lstate_t;
endpackage
`default_nettype wire

// [bench/ssr_encoder_model.sv]
// Behavioural absolute position encoder on the far side of the serial link
`default_nettype none
module ssr_encoder_model #(
  parameter int MONO_NS = 360
) (
  // Link
  input wire logic encoderClockOut,
  output logic encoderDataIn,
  // Test controls
  input wire logic [4:0] nBits,
  input wire logic [30:0] word,
  input wire logic corrupt,
  input wire logic wireCut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dataR = 1'b1;
  logic active = 1'b0;
  logic odd = 1'b0;
  logic [30:0] shiftW;
  int idx;
  realtime lastEdge;
  // A cut pair reads low at the receiver
  assign encoderDataIn = wireCut ? 1'b0 : dataR;
  // First fall freezes the word; every other copy may be spoilt on demand
  always @(negedge encoderClockOut) begin
    lastEdge = $realtime;
    if (!active) begin
      active = 1'b1;
      idx = nBits;
      shiftW = (corrupt && odd) ? word ^ 31'h1 : word;
      odd = !odd;
    end
  end
  always @(posedge encoderClockOut) begin
    lastEdge = $realtime;
    if (active && idx > 0) begin
      idx = idx - 1;
      dataR = shiftW[idx];
    end else if (active) begin
      dataR = 1'b0;
    end
  end
  // Monoflop: shorter than one repeat gap, longer than one half period
  always begin
    #10;
    if (active && encoderClockOut && $realtime - lastEdge > MONO_NS) begin
      active = 1'b0;
      dataR = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the encoder reader: APB tasks, link monitor, scenarios
`default_nettype none
module testbench
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic linkClk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, encoderClockOut, encoderDataIn;
  logic latchTriggerInput = 1'b0;
  logic sysStatusBlue, sysStatusRed, ledCommOk, ledFwd, ledRev, ledCmp1, ledCmp2, ledLatchIn;
  logic [4:0] nBits = 5'h0d;
  logic [30:0] word = 31'h0;
  logic corrupt = 1'b0;
  logic wireCut = 1'b0;
  int fails = 0;
  int samplesChecked = 0;
  int pl, lw, id, t;
  logic [31:0] q;
  logic e;

  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  ssr_encoder_reader #(.BLINK_CYC(8)) dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linkClk(linkClk), .encoderClockOut(encoderClockOut),
    .encoderDataIn(encoderDataIn), .latchTriggerInput(latchTriggerInput),
    .sysStatusBlue(sysStatusBlue), .sysStatusRed(sysStatusRed), .ledCommOk(ledCommOk),
    .ledFwd(ledFwd), .ledRev(ledRev), .ledCmp1(ledCmp1), .ledCmp2(ledCmp2),
    .ledLatchIn(ledLatchIn));
  ssr_encoder_model enc (.encoderClockOut(encoderClockOut), .encoderDataIn(encoderDataIn),
    .nBits(nBits), .word(word), .corrupt(corrupt), .wireCut(wireCut));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    samplesChecked++;
    if (y !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      print_verdict();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask

  // Polls until the masked register settles, bounded by a few frames
  task automatic er(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    logic [31:0] rq;
    logic re;
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, a, 32'h0, rq, re);
      if ((rq & m) === x) break;
    end
    chk(nm, x, rq & m);
  endtask

  // Settings may only change while stopped, so stop first and restart
  task automatic cfg(input int nb, input int sp, input logic [31:0] fl);
    logic [31:0] c;
    c = 32'(nb) | (32'(sp) << CT_SPEC) | (32'h1 << CT_ADMIT) | fl;
    wr(OFS_CTRL, c);
    wr(OFS_CTRL, c | (32'h1 << CT_RUN));
  endtask

  // Measures one burst from a frame start: pulses, first low width, idle after it
  task automatic burst(output int pulses, output int lowW, output int idle);
    int i, qt;
    logic prev;
    qt = 0;
    for (i = 0; i < 40000 && qt < 130; i++) begin
      @(posedge linkClk);
      qt = (encoderClockOut === 1'b1) ? qt + 1 : 0;
    end
    for (i = 0; i < 40000 && encoderClockOut !== 1'b0; i++) @(posedge linkClk);
    pulses = 1;
    lowW = 0;
    prev = 1'b0;
    qt = 0;
    // End of burst: longer than one high half period, shorter than the repeat gap
    for (i = 0; i < 40000 && qt < 60; i++) begin
      if (pulses == 1 && encoderClockOut === 1'b0) lowW++;
      @(posedge linkClk);
      if (prev && encoderClockOut === 1'b0) pulses++;
      prev = encoderClockOut;
      qt = prev ? qt + 1 : 0;
    end
    idle = qt;
    for (i = 0; i < 40000 && encoderClockOut !== 1'b0; i++) begin
      @(posedge linkClk);
      idle++;
    end
  endtask

  task automatic toggles(input logic red, output int n);
    logic b;
    n = 0;
    b = red ? sysStatusRed : sysStatusBlue;
    for (int i = 0; i < 80; i++) begin
      @(posedge mclk);
      if ((red ? sysStatusRed : sysStatusBlue) !== b) n++;
      b = red ? sysStatusRed : sysStatusBlue;
    end
  endtask

  function automatic logic [30:0] wd(input int p);
    return (31'(p) << 4) | 31'ha;
  endfunction

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    er("ctrl reset", OFS_CTRL, 32'hffffffff, CTRL_RST);
    er("div reset", OFS_DIV, 32'hffffffff, 32'(DIV_RST));
    er("unconfigured", OFS_STATUS, 32'h1 << ST_CONFIGURED, 32'h0);
    chk("clock rest", 32'h1, 32'(encoderClockOut));
    toggles(1'b0, t);
    chk("idle blink", 32'h1, 32'(t > 2));
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    wr(OFS_DIV, 32'h0000000a);
    er("div clamp", OFS_DIV, 32'h0000ffff, 32'(DIV_MIN));
    word = wd(100);
    cfg(13, 4, 32'h0);
    er("raw value", OFS_VALUE, 32'hffffffff, 32'h0000064a);
    er("comm ok", OFS_STATUS, 32'h1 << ST_COMM_OK, 32'h1 << ST_COMM_OK);
    chk("comm led", 32'h1, 32'(ledCommOk));
    toggles(1'b0, t);
    chk("run solid", 32'h0, 32'(t));
    burst(pl, lw, id);
    chk("pulses", 32'd14, 32'(pl));
    chk("half period", 32'(DIV_MIN), 32'(lw));
    chk("idle", 32'h1, 32'(id >= 2 * DIV_MIN));
    cfg(13, 4, 32'h1 << CT_NORM);
    er("normalized", OFS_VALUE, 32'hffffffff, 32'd100);
    word = (31'h56 << 4) | 31'ha;
    cfg(13, 4, 32'h1 << CT_GRAY);
    er("gray", OFS_VALUE, 32'hffffffff, 32'h0000064a);
    nBits = 5'h08;
    word = 31'h000000c3;
    cfg(8, 0, 32'h0);
    er("min width", OFS_VALUE, 32'hffffffff, 32'h000000c3);
    nBits = 5'h1f;
    word = 31'h5a5a5a5a;
    cfg(31, 0, 32'h0);
    er("max width", OFS_VALUE, 32'hffffffff, 32'h5a5a5a5a);
    burst(pl, lw, id);
    chk("max pulses", 32'd32, 32'(pl));
    cfg(7, 0, 32'h0);
    er("param err", OFS_STATUS, 32'h1 << ST_PARAM_ERR, 32'h1 << ST_PARAM_ERR);
    toggles(1'b1, t);
    chk("param blink", 32'h1, 32'(t > 0));
    nBits = 5'h0e;
    word = {wd(100), 1'b0} | 31'(^wd(100));
    cfg(14, 4, 32'h1 << CT_PAR_EN);
    wr(OFS_STATUS, 32'h00000380);
    er("parity value", OFS_VALUE, 32'hffffffff, 32'h0000064a);
    er("parity good", OFS_STATUS, 32'h1 << ST_PAR_ERR, 32'h0);
    word = word ^ 31'h1;
    er("parity bad", OFS_STATUS, 32'h1 << ST_PAR_ERR, 32'h1 << ST_PAR_ERR);
    nBits = 5'h0d;
    word = wd(100);
    cfg(13, 4, 32'h1 << CT_REPEAT);
    wr(OFS_STATUS, 32'h00000380);
    er("copies agree", OFS_STATUS, 32'h1 << ST_TX_ERR, 32'h0);
    burst(pl, lw, id);
    chk("repeat pulses", 32'd14, 32'(pl));
    chk("repeat gap", 32'h1, 32'(id >= 2 * DIV_MIN));
    corrupt = 1'b1;
    er("copies differ", OFS_STATUS, 32'h1 << ST_TX_ERR, 32'h1 << ST_TX_ERR);
    corrupt = 1'b0;
    wr(OFS_CMP1, 32'd110);
    wr(OFS_CMP2, 32'd90);
    cfg(13, 4, (32'h1 << CT_NORM) | (32'h1 << CT_CMP1) | (32'h2 << CT_CMP2));
    er("start pos", OFS_VALUE, 32'hffffffff, 32'd100);
    word = wd(120);
    er("forward", OFS_STATUS, 32'h1 << ST_FWD, 32'h1 << ST_FWD);
    chk("fwd led", 32'h1, 32'(ledFwd));
    er("cmp1 fwd", OFS_STATUS, 32'h1 << ST_CMP1, 32'h1 << ST_CMP1);
    chk("cmp1 led", 32'h1, 32'(ledCmp1));
    word = wd(80);
    er("reverse", OFS_STATUS, 32'h1 << ST_REV, 32'h1 << ST_REV);
    chk("rev led", 32'h1, 32'(ledRev));
    er("cmp2 rev", OFS_STATUS, 32'h1 << ST_CMP2, 32'h1 << ST_CMP2);
    chk("cmp2 led", 32'h1, 32'(ledCmp2));
    cfg(13, 4, (32'h1 << CT_NORM) | (32'h1 << CT_DIR_INV));
    word = wd(100);
    er("inverted dir", OFS_STATUS, 32'h1 << ST_REV, 32'h1 << ST_REV);
    word = wd(80);
    cfg(13, 4, (32'h1 << CT_NORM) | (32'h1 << CT_LATCH_EN));
    er("pre latch", OFS_VALUE, 32'hffffffff, 32'd80);
    latchTriggerInput <= 1'b1;
    er("latched", OFS_STATUS, 32'h1 << ST_LATCH_VALID, 32'h1 << ST_LATCH_VALID);
    chk("latch led", 32'h1, 32'(ledLatchIn));
    word = wd(60);
    er("moved on", OFS_VALUE, 32'hffffffff, 32'd60);
    er("latch held", OFS_LATCH, 32'hffffffff, 32'd80);
    wireCut = 1'b1;
    er("wire break", OFS_STATUS, 32'h1 << ST_WIRE_BREAK, 32'h1 << ST_WIRE_BREAK);
    toggles(1'b1, t);
    chk("red solid", 32'h1, 32'((t == 0) && (sysStatusRed === 1'b1)));
    print_verdict();
  end
endmodule
`default_nettype wire
